// ---- common/rscl_consts.svh ----
// Purpose: constants of the reset strap configuration latch
// Assumes: 125 MHz master clock
// Notes:   host interface codes are the three low strap bits
`ifndef RSCL_CONSTS_SVH
`define RSCL_CONSTS_SVH
`define RSCL_HOST_DATA_WIDTH   16
`define RSCL_STRAP_WIDTH       4
`define RSCL_ENDIAN_BIT        3
`define RSCL_CODE_PROC_1       3'h0
`define RSCL_CODE_PROC_2       3'h1
`define RSCL_CODE_68K_1        3'h3
`define RSCL_CODE_68K_2        3'h5
`define RSCL_CODE_GENERIC      3'h7
`define RSCL_DISPLAY_INPUT_CLOCK_MAX_DIV_MHZ  50
`define RSCL_DISPLAY_INPUT_CLOCK_MAX_NODIV_MHZ 25
`endif

// ---- common/rscl_pkg.sv ----
// Purpose: types of the reset strap configuration latch
// Assumes: nothing
// Notes:   none
package rscl_pkg;
	typedef enum logic [2:0] {
		RSCL_BUS_PROC_1,
		RSCL_BUS_PROC_2,
		RSCL_BUS_68K_1,
		RSCL_BUS_68K_2,
		RSCL_BUS_GENERIC_1,
		RSCL_BUS_GENERIC_2,
		RSCL_BUS_RESERVED
	} rscl_bus_t;
endpackage

// ---- logic/rscl_sync.sv ----
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to the clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module rscl_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,  // clock
	input  wire logic             i_rst,  // synchronous reset, high
	input  wire logic [WIDTH-1:0] i_d,    // asynchronous levels
	output logic      [WIDTH-1:0] o_q     // synchronised levels
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			stage1 <= '0;
			stage2 <= '0;
		end
		else
		begin
			stage1 <= i_d;
			stage2 <= stage1;
		end
	end
	assign o_q = stage2;
endmodule // rscl_sync

// ---- logic/rscl_latch.sv ----
// Purpose: capture configuration straps at the rising edge of the pin reset
// Assumes: straps stable around the reset release; 125 MHz master clock
// Notes:   the pin reset is synchronised, so capture follows its release by 3 clocks
//
// Summary of operation
// R1 - on pin reset rising edge, sample four straps and bus start, then hold
// R2 - low three strap bits select host bus type; 010, 100, 110 reserved
// R3 - every selected host bus is 16 bits wide
// R4 - fourth strap high gives big endian, low gives little endian
// R5 - generic code: bus start low picks generic one, high picks generic two
// R6 - panel power enable output is active high only
// R7 - outside party keeps display clock at most 50 MHz divided, 25 MHz undivided
// R8 - general pin zero high at reset edge enables hardware suspend
`timescale 1ns/1ps
`include "rscl_consts.svh"
module rscl_latch #(
	parameter int HOST_WIDTH = `RSCL_HOST_DATA_WIDTH
) (
	input  wire logic                           I_MCLK,                 // master clock
	input  wire logic                           I_SYS_RST,              // sync reset, high
	input  wire logic                           I_PIN_RST_N,            // device reset pin
	input  wire logic [`RSCL_STRAP_WIDTH-1:0]   I_CONFIG_STRAP_PINS,    // strap pins
	input  wire logic                           I_BUS_START_STROBE_N,   // bus start pin
	input  wire logic                           I_GENERAL_PIN_ZERO,     // suspend strap
	input  wire logic                           I_PANEL_POWER_REQ,      // panel power request
	input  wire logic                           I_DISPLAY_INPUT_CLOCK_DIV_EN,          // clock divider in use
	output logic                                O_CONFIG_VALID,         // straps captured
	output rscl_pkg::rscl_bus_t                 O_HOST_BUS,             // selected host bus
	output logic                                O_HOST_BUS_RESERVED,    // reserved code seen
	output logic [7:0]                          O_HOST_DATA_WIDTH,      // bus width in bits
	output logic                                O_BIG_ENDIAN,           // big endian bus
	output logic                                O_HW_SUSPEND_EN,        // hw suspend enable
	output logic                                O_PANEL_POWER_ENABLE,   // panel power, high
	output logic [7:0]                          O_DISPLAY_INPUT_CLOCK_MAX_MHZ          // allowed display clock
);
	localparam int SW = `RSCL_STRAP_WIDTH + 3;

	logic [SW-1:0]       pins_sync;
	logic                rst_pin_prev;
	logic                next_rst_pin_prev;
	logic                valid;
	logic                next_valid;
	logic [3:0]          strap;
	logic [3:0]          next_strap;
	logic                bs_level;
	logic                next_bs_level;
	logic                gp0;
	logic                next_gp0;
	logic                pwr;
	logic                next_pwr;
	logic                div_en;
	logic                next_div_en;
	rscl_pkg::rscl_bus_t bus;
	rscl_pkg::rscl_bus_t next_bus;
	logic                rise;

	rscl_sync #(
		.WIDTH (SW)
	) u_sync (
		.i_clk (I_MCLK),
		.i_rst (I_SYS_RST),
		.i_d   ({I_PIN_RST_N, I_CONFIG_STRAP_PINS, I_BUS_START_STROBE_N, I_GENERAL_PIN_ZERO}),
		.o_q   (pins_sync)
	);

	assign rise = pins_sync[SW-1] & ~rst_pin_prev;

	always_comb
	begin
		next_rst_pin_prev = pins_sync[SW-1];
		next_valid        = valid;
		next_strap        = strap;
		next_bs_level     = bs_level;
		next_gp0          = gp0;
		next_pwr          = I_PANEL_POWER_REQ;          // see R6
		next_div_en       = I_DISPLAY_INPUT_CLOCK_DIV_EN;
		if (!pins_sync[SW-1])
			next_valid = 1'b0;
		if (rise)
		begin
			next_strap    = pins_sync[SW-2:2];          // see R1
			next_bs_level = pins_sync[1];               // see R1
			next_gp0      = pins_sync[0];               // see R8
			next_valid    = 1'b1;
		end
		case (next_strap[2:0])                          // see R2
			`RSCL_CODE_PROC_1:  next_bus = rscl_pkg::RSCL_BUS_PROC_1;
			`RSCL_CODE_PROC_2:  next_bus = rscl_pkg::RSCL_BUS_PROC_2;
			`RSCL_CODE_68K_1:   next_bus = rscl_pkg::RSCL_BUS_68K_1;
			`RSCL_CODE_68K_2:   next_bus = rscl_pkg::RSCL_BUS_68K_2;
			`RSCL_CODE_GENERIC: next_bus = next_bs_level ? rscl_pkg::RSCL_BUS_GENERIC_2
				: rscl_pkg::RSCL_BUS_GENERIC_1;            // see R5
			default:            next_bus = rscl_pkg::RSCL_BUS_RESERVED;
		endcase
	end

	always_ff @(posedge I_MCLK)
	begin
		if (I_SYS_RST)
		begin
			rst_pin_prev <= 1'b0;
			valid        <= 1'b0;
			strap        <= 4'h0;
			bs_level     <= 1'b0;
			gp0          <= 1'b0;
			pwr          <= 1'b0;
			div_en       <= 1'b0;
			bus          <= rscl_pkg::RSCL_BUS_PROC_1;
		end
		else
		begin
			rst_pin_prev <= next_rst_pin_prev;
			valid        <= next_valid;
			strap        <= next_strap;
			bs_level     <= next_bs_level;
			gp0          <= next_gp0;
			pwr          <= next_pwr;
			div_en       <= next_div_en;
			bus          <= next_bus;
		end
	end

	assign O_CONFIG_VALID       = valid;
	assign O_HOST_BUS           = bus;
	assign O_HOST_BUS_RESERVED  = (bus == rscl_pkg::RSCL_BUS_RESERVED);
	assign O_HOST_DATA_WIDTH    = 8'(HOST_WIDTH);                       // see R3
	assign O_BIG_ENDIAN         = strap[`RSCL_ENDIAN_BIT];              // see R4
	assign O_HW_SUSPEND_EN      = gp0;                                  // see R8
	assign O_PANEL_POWER_ENABLE = pwr;                                  // see R6
	// advisory limit for the clock the outside party supplies
	assign O_DISPLAY_INPUT_CLOCK_MAX_MHZ       = div_en ? 8'(`RSCL_DISPLAY_INPUT_CLOCK_MAX_DIV_MHZ)
		: 8'(`RSCL_DISPLAY_INPUT_CLOCK_MAX_NODIV_MHZ);                                 // see R7
endmodule // rscl_latch

// ---- test/rscl_chk.sv ----
// Purpose: latch port checks. Assumes: one clock. Notes: bound at foot.
`timescale 1ns/1ps
module rscl_chk (
	input wire logic I_MCLK, I_SYS_RST, I_PIN_RST_N, I_BUS_START_STROBE_N,
	input wire logic I_GENERAL_PIN_ZERO, I_PANEL_POWER_REQ, O_CONFIG_VALID,
	input wire logic O_HOST_BUS_RESERVED, O_BIG_ENDIAN, O_HW_SUSPEND_EN, O_PANEL_POWER_ENABLE,
	input wire logic [3:0] I_CONFIG_STRAP_PINS,
	input wire logic [7:0] O_HOST_DATA_WIDTH,
	input rscl_pkg::rscl_bus_t O_HOST_BUS
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);
	sequence s_rise; $rose(I_PIN_RST_N); endsequence
	a_cap_valid: assert property (s_rise |-> ##2 !O_CONFIG_VALID ##1 O_CONFIG_VALID)
		else $error("late");
	a_bus_rsv: assert property (s_rise |-> ##3 O_HOST_BUS_RESERVED ==
		$past(I_CONFIG_STRAP_PINS[2:0] inside {3'h2, 3'h4, 3'h6}, 3)) else $error("rsv");
	a_gen_sel: assert property (s_rise ##0 I_CONFIG_STRAP_PINS[2:0] == 3'h7 |-> ##3
		O_HOST_BUS == rscl_pkg::RSCL_BUS_GENERIC_1 + $past(I_BUS_START_STROBE_N, 3))
		else $error("gen");
	a_endian_cap: assert property (s_rise |-> ##3
		O_BIG_ENDIAN == $past(I_CONFIG_STRAP_PINS[3], 3)) else $error("endian");
	a_susp_cap: assert property (s_rise |-> ##3
		O_HW_SUSPEND_EN == $past(I_GENERAL_PIN_ZERO, 3)) else $error("suspend");
	a_width_16: assert property (O_HOST_DATA_WIDTH == 8'h10) else $error("width");
	a_pwr_high: assert property (1 |=> O_PANEL_POWER_ENABLE == $past(I_PANEL_POWER_REQ))
		else $error("power");
endmodule // rscl_chk
bind rscl_latch rscl_chk rscl_chk_inst (.*);

// ---- test/rscl_host_mdl.sv ----
// Purpose: host pulsing reset and straps. Assumes: one pulse at once. Notes: none.
`timescale 1ns/1ps
module rscl_host_mdl (
	input  wire logic       i_clk, // clock
	input  wire logic       i_go,  // start pulse
	input  wire logic [5:0] i_cfg, // strap levels
	output logic            o_rst_n, // reset pin
	output logic [5:0]      o_pins // strap pins
);
	logic [3:0] cnt = 4'h0;
	always @(posedge i_clk)
		cnt <= i_go ? 4'h9 : cnt - 4'(cnt != 4'h0);
	assign o_rst_n = cnt < 4'h7;
	assign o_pins = (cnt != 4'h0) ? i_cfg : ~i_cfg; // held past capture, then moved
endmodule // rscl_host_mdl

// ---- test/testbench.sv ----
// Purpose: latch self-check. Assumes: one clock. Notes: host model drives straps.
`timescale 1ns/1ps
module testbench;
	logic I_MCLK = 1'b0, I_SYS_RST = 1'b1, I_PANEL_POWER_REQ = 1'b0, go = 1'b0;
	logic I_DISPLAY_INPUT_CLOCK_DIV_EN = 1'b1; // display clock kept within limit
	logic I_PIN_RST_N, I_BUS_START_STROBE_N, I_GENERAL_PIN_ZERO, O_CONFIG_VALID;
	logic O_HOST_BUS_RESERVED, O_BIG_ENDIAN, O_HW_SUSPEND_EN, O_PANEL_POWER_ENABLE;
	logic [3:0] I_CONFIG_STRAP_PINS;
	logic [5:0] cfg = 6'h00;
	logic [7:0] O_HOST_DATA_WIDTH, O_DISPLAY_INPUT_CLOCK_MAX_MHZ;
	rscl_pkg::rscl_bus_t O_HOST_BUS;
	int err_count = 0, num_checks = 0, cyc = 0;
	logic [2:0] map [8] = '{3'h0, 3'h1, 3'h6, 3'h2, 3'h6, 3'h3, 3'h6, 3'h4}; // bus type per code
	rscl_latch rscl_latch_inst (.*);
	rscl_host_mdl rscl_host_mdl_inst (.i_clk(I_MCLK), .i_go(go), .i_cfg(cfg), .o_rst_n(I_PIN_RST_N),
		.o_pins({I_GENERAL_PIN_ZERO, I_BUS_START_STROBE_N, I_CONFIG_STRAP_PINS}));
	initial forever #4 I_MCLK = ~I_MCLK;
	always @(posedge I_MCLK)
		if (++cyc == 2000) end_sim(1);
	task automatic chk(string n, logic [7:0] e, s);
		num_checks++;
		err_count += int'(s !== e);
		if (s !== e)
			$display("[FAIL] %s expected %h seen %h", n, e, s);
	endtask
	task automatic end_sim(int bad);
		$display("checks %0d mismatches %0d", num_checks, err_count + bad);
		if (err_count + bad == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cfg_scn(logic [5:0] c);
		cfg = c;
		go = 1'b1;
		@(posedge I_MCLK) #1 go = 1'b0;
		#96;
		chk("valid", 8'h01, {7'h0, O_CONFIG_VALID});
		chk("bus", {5'h0, map[c[2:0]] + 3'(c[2:0] == 3'h7 && c[4])}, {5'h0, O_HOST_BUS});
		chk("width", 8'h10, O_HOST_DATA_WIDTH);
		chk("endian", {7'h0, c[3]}, {7'h0, O_BIG_ENDIAN});
		chk("suspend", {7'h0, c[5]}, {7'h0, O_HW_SUSPEND_EN});
	endtask
	task automatic pwr_scn(logic v);
		I_PANEL_POWER_REQ = v;
		@(posedge I_MCLK) #1;
		chk("power", {7'h0, v}, {7'h0, O_PANEL_POWER_ENABLE});
	endtask
	task automatic clk_scn(logic v, logic [7:0] e);
		I_DISPLAY_INPUT_CLOCK_DIV_EN = v;
		@(posedge I_MCLK) #1;
		chk("clk_max", e, O_DISPLAY_INPUT_CLOCK_MAX_MHZ);
	endtask
	initial
	begin
		#21 I_SYS_RST = 1'b0;
		for (int i = 0; i < 16; i++) cfg_scn({i[0] ^ i[3], i[3], i[3:0]});
		pwr_scn(1'b1);
		pwr_scn(1'b0);
		clk_scn(1'b0, 8'h19);
		clk_scn(1'b1, 8'h32);
		end_sim(0);
	end
endmodule // testbench
